// ==== rtl/adcsc_consts.svh ====
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// ==========================================================
// Register addresses of the serial map.
`define ADCSC_ADDR_PORTCFG 13'h0000
`define ADCSC_ADDR_PARTID 13'h0001
`define ADCSC_ADDR_GRADE 13'h0002
`define ADCSC_ADDR_CHSEL 13'h0005
`define ADCSC_ADDR_XFER 13'h00ff
`define ADCSC_ADDR_FUNC_LO 13'h0008
`define ADCSC_ADDR_FUNC_HI 13'h0022

// ==========================================================
// Reset values.
`define ADCSC_RST_PORTCFG 8'h18
`define ADCSC_RST_CHSEL 6'h0f
`define ADCSC_RST_XFER 8'h00

// ==========================================================
// Field positions.
`define ADCSC_PC_LSB_HI 6
`define ADCSC_PC_SRST_HI 5
`define ADCSC_PC_SRST_LO 2
`define ADCSC_PC_LSB_LO 1
`define ADCSC_XFER_BIT 0
`define ADCSC_INS_RD 15
`define ADCSC_LEN_STREAM 2'h3

`endif

// ==== rtl/adcsc_pkg.sv ====
package adcsc_pkg;

  // Phase of the serial frame.
  typedef enum logic [1:0] {
    PH_INSTR_HI,
    PH_INSTR_LO,
    PH_DATA
  } adcsc_phase_t;

  // Decoded instruction word.
  typedef struct packed {
    logic rd;
    logic [1:0] len;
    logic [12:0] addr;
  } adcsc_frame_t;

  // Write forwarded to the converter-function registers.
  typedef struct packed {
    logic valid;
    logic [12:0] addr;
    logic [7:0] data;
    logic [5:0] targets;
  } adcsc_wr_t;

endpackage

// ==== rtl/adcsc_regs.sv ====
`timescale 1ns/1ns
`include "adcsc_consts.svh"

// Notes on behaviour
// - Any reset reloads every register default.
// - Undefined bits are not stored, read zero.
// - Bits 3,2 select channels D,C; default set.
// - Bits 1,0 select channels B,A as targets.
// - Set means logic one, clear logic zero.
// - Shift MSB first until bit order changes.
// - Select released mid-byte resets the frame.
module adcsc_regs #(
  parameter logic [7:0] PART_ID = 8'h5a,     // Arbitrary identification value.
  parameter logic [2:0] VARIANT_CODE = 3'h2  // Arbitrary variant value.
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic lsb_first,
  output logic [5:0] chan_sel,
  output logic software_commit_bit,
  output adcsc_pkg::adcsc_wr_t fn_wr
);
  import adcsc_pkg::*;

  // ==========================================================
  // Serial state.
  logic sclk_q;
  logic [2:0] bitcnt;
  logic [7:0] rx_sh;
  logic [7:0] ins_first;
  logic [7:0] tx_sh;
  logic [1:0] data_cnt;
  adcsc_phase_t phase;
  adcsc_frame_t frame;

  // Readback value of one address; function space reads as zero here.
  function automatic logic [7:0] rd_value(input logic [12:0] a, input logic lsb,
                                          input logic [5:0] sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ADCSC_ADDR_PORTCFG: v = `ADCSC_RST_PORTCFG | {1'b0, lsb, 4'h0, lsb, 1'b0};
      `ADCSC_ADDR_PARTID: v = PART_ID;
      `ADCSC_ADDR_GRADE: v = {1'b0, VARIANT_CODE, 4'h0};
      `ADCSC_ADDR_CHSEL: v = {2'b00, sel};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Edge detection and byte assembly.
  wire sclk_rise = sclk & ~sclk_q;
  wire sclk_fall = ~sclk & sclk_q;
  wire active = ~serial_select_n;
  wire bit_rise = active & sclk_rise;
  wire byte_done = bit_rise & (bitcnt == 3'd7);
  wire [7:0] next_rx = lsb_first ? {sdio_i, rx_sh[7:1]} : {rx_sh[6:0], sdio_i};
  wire [15:0] instr = lsb_first ? {next_rx, ins_first} : {ins_first, next_rx};
  wire in_data = (phase == PH_DATA);
  wire wr_fire = byte_done & in_data & ~frame.rd;
  wire last_byte = (frame.len != `ADCSC_LEN_STREAM) && (data_cnt == frame.len);
  wire data_end = byte_done & in_data & last_byte;
  // Address walks down in MSB-first order and up in LSB-first order.
  wire [12:0] next_addr = lsb_first ? 13'(frame.addr + 13'd1) : 13'(frame.addr - 13'd1);
  // Between whole data bytes of a counted transfer the select may pause.
  wire release_sel = serial_select_n &
    ((bitcnt != 3'd0) || !in_data || (frame.len == `ADCSC_LEN_STREAM));
  wire ins_done = byte_done & (phase == PH_INSTR_LO);
  wire wr_portcfg = wr_fire & (frame.addr == `ADCSC_ADDR_PORTCFG);
  wire soft_rst = wr_portcfg & (next_rx[`ADCSC_PC_SRST_HI] | next_rx[`ADCSC_PC_SRST_LO]);
  wire wr_chsel = wr_fire & (frame.addr == `ADCSC_ADDR_CHSEL);
  wire wr_xfer = wr_fire & (frame.addr == `ADCSC_ADDR_XFER);
  wire wr_func = wr_fire & (frame.addr >= `ADCSC_ADDR_FUNC_LO) &
    (frame.addr <= `ADCSC_ADDR_FUNC_HI);

  // Edge history of the serial clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Frame sequencer: instruction bytes, then data bytes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bitcnt <= 3'd0;
      rx_sh <= 8'h00;
      ins_first <= 8'h00;
      phase <= PH_INSTR_HI;
      frame <= '0;
      data_cnt <= 2'd0;
    end else if (release_sel) begin
      bitcnt <= 3'd0;
      phase <= PH_INSTR_HI;
      data_cnt <= 2'd0;
    end else if (bit_rise) begin
      bitcnt <= 3'(bitcnt + 3'd1);
      rx_sh <= next_rx;
      if (byte_done) begin
        unique case (phase)
          PH_INSTR_HI: begin
            ins_first <= next_rx;
            phase <= PH_INSTR_LO;
          end
          PH_INSTR_LO: begin
            frame.rd <= instr[`ADCSC_INS_RD];
            frame.len <= instr[14:13];
            frame.addr <= instr[12:0];
            data_cnt <= 2'd0;
            phase <= PH_DATA;
          end
          PH_DATA: begin
            frame.addr <= next_addr;
            data_cnt <= 2'(data_cnt + 2'd1);
            if (data_end) begin
              phase <= PH_INSTR_HI;
            end
          end
        endcase
      end
    end
  end

  // Readback shifter: loaded at a byte boundary, bit presented on falling edges.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_sh <= 8'h00;
      sdio_o <= 1'b0;
    end else if (ins_done) begin
      tx_sh <= rd_value(instr[12:0], lsb_first, chan_sel);
    end else if (byte_done & in_data & frame.rd) begin
      tx_sh <= rd_value(next_addr, lsb_first, chan_sel);
    end else if (active & sclk_fall & in_data & frame.rd) begin
      sdio_o <= lsb_first ? tx_sh[0] : tx_sh[7];
      tx_sh <= lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
    end
  end

  // The pin turns round only inside the data phase of a read.
  assign sdio_oe = active & in_data & frame.rd;

  // Control registers; soft reset behaves like the pin reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lsb_first <= 1'b0;
      chan_sel <= `ADCSC_RST_CHSEL;
      software_commit_bit <= 1'b0;
    // The soft reset stays synchronous so the async branch sees the pin alone.
    end else if (soft_rst) begin
      lsb_first <= 1'b0;
      chan_sel <= `ADCSC_RST_CHSEL;
      software_commit_bit <= 1'b0;
    end else begin
      software_commit_bit <= wr_xfer & next_rx[`ADCSC_XFER_BIT];
      if (wr_portcfg) begin
        lsb_first <= next_rx[`ADCSC_PC_LSB_HI] | next_rx[`ADCSC_PC_LSB_LO];
      end
      if (wr_chsel) begin
        chan_sel <= next_rx[5:0];
      end
    end
  end

  // Function-register writes leave with the current target mask.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fn_wr <= '0;
    end else begin
      fn_wr.valid <= wr_func;
      if (wr_func) begin
        fn_wr.addr <= frame.addr;
        fn_wr.data <= next_rx;
        fn_wr.targets <= chan_sel;
      end
    end
  end

  // ==========================================================
  // Assertions.
  property p_reset_defaults;
    @(posedge mclk) $fell(rst) |-> (chan_sel == 6'h0f) && !lsb_first && !software_commit_bit;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults missing");

  property p_undef_zero;
    @(posedge mclk) disable iff (rst)
      ins_done && (instr[12:0] == `ADCSC_ADDR_CHSEL) |=> tx_sh[7:6] == 2'b00;
  endproperty
  a_undef_zero: assert property (p_undef_zero) else $error("undefined bits read set");

  property p_chsel_write;
    @(posedge mclk) disable iff (rst) wr_chsel |=> chan_sel == $past(next_rx[5:0]);
  endproperty
  a_chsel_write: assert property (p_chsel_write) else $error("channel mask not stored");

  property p_targets;
    @(posedge mclk) disable iff (rst) wr_func |=> fn_wr.valid && fn_wr.targets == $past(chan_sel);
  endproperty
  a_targets: assert property (p_targets) else $error("write targets wrong");

  property p_polarity;
    @(posedge mclk) disable iff (rst)
      wr_portcfg && !soft_rst && next_rx[6] |=> lsb_first;
  endproperty
  a_polarity: assert property (p_polarity) else $error("set bit not honoured");

  property p_msb_hold;
    @(posedge mclk) disable iff (rst) !lsb_first && !wr_portcfg |=> !lsb_first;
  endproperty
  a_msb_hold: assert property (p_msb_hold) else $error("bit order changed");

  property p_abort;
    @(posedge mclk) disable iff (rst)
      serial_select_n && bitcnt != 3'd0 |=> bitcnt == 3'd0 && phase == PH_INSTR_HI;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not reset");

  property p_commit;
    @(posedge mclk) disable iff (rst)
      wr_xfer && next_rx[0] && !soft_rst |=> software_commit_bit ##1 !software_commit_bit;
  endproperty
  a_commit: assert property (p_commit) else $error("commit not one pulse");

  property p_oe_read;
    @(posedge mclk) disable iff (rst) sdio_oe |-> frame.rd && !serial_select_n;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("pin driven outside read");

  c_commit: cover property (@(posedge mclk) disable iff (rst) software_commit_bit);
  c_read: cover property (@(posedge mclk) disable iff (rst) sdio_oe ##1 sclk_fall);
  c_stream: cover property (@(posedge mclk) disable iff (rst)
    wr_fire && frame.len == 2'h3);
  c_soft: cover property (@(posedge mclk) disable iff (rst) soft_rst);

endmodule

// ==== testbench/adcsc_host.sv ====
`timescale 1ns/1ns
// ==========================================
// Serial host model driving the 3-wire port.
module adcsc_host (
  input wire logic mclk,
  input wire logic lsb_mode,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  output logic sclk,
  output logic serial_select_n,
  output logic sdio_i
);
  logic drv = 1'b1;
  logic bit_q = 1'b0;
  // A released line shows the inverse of its last value, so a stale copy never passes.
  assign sdio_i = sdio_oe ? sdio_o : (drv ? bit_q : ~bit_q);
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
  end
  // One frame: 16 instruction bits, then data bytes that all repeat wd.
  // Fewer bits than a whole byte abort it; rq keeps the last byte read.
  task automatic frame(input logic rd, input logic [1:0] ln, input logic [12:0] a,
                       input logic [7:0] wd, input int nbits, output logic [7:0] rq);
    logic [23:0] w;
    int i;
    int j;
    w = {rd, ln, a, wd};
    rq = 8'h00;
    @(posedge mclk) #1 serial_select_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      drv = !(rd && i >= 16);
      j = (i - 16) & 7;
      if (drv) bit_q = i < 16 ? (lsb_mode ? w[i + 8] : w[23 - i]) : (lsb_mode ? wd[j] : wd[7 - j]);
      repeat (4) @(posedge mclk);
      #1 sclk = 1'b1;
      if (!drv) rq[lsb_mode ? j : 7 - j] = sdio_i;
      repeat (4) @(posedge mclk);
      #1 sclk = 1'b0;
    end
    repeat (4) @(posedge mclk);
    #1 serial_select_n = 1'b1;
    drv = 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the configuration registers.
module tb_top;
  import adcsc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic lsb_mode = 1'b0;
  logic sclk, serial_select_n, sdio_i, sdio_o, sdio_oe, lsb_first, software_commit_bit;
  logic [5:0] chan_sel;
  adcsc_wr_t fn_wr;
  adcsc_wr_t last_wr = '0;
  int fail_count = 0;
  int n_checks = 0;
  int n_wr = 0;
  int n_commit = 0;
  int i;
  logic [7:0] rq, v;
  logic [12:0] a;

  always #5 mclk = ~mclk;

  adcsc_regs u_adcsc_regs (.mclk(mclk), .rst(rst), .sclk(sclk),
    .serial_select_n(serial_select_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .lsb_first(lsb_first), .chan_sel(chan_sel),
    .software_commit_bit(software_commit_bit), .fn_wr(fn_wr));
  adcsc_host u_adcsc_host (.mclk(mclk), .lsb_mode(lsb_mode), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .sclk(sclk), .serial_select_n(serial_select_n), .sdio_i(sdio_i));

  // Pulses last one cycle, so they are caught here as they pass.
  always @(posedge mclk) begin
    if (fn_wr.valid === 1'b1) begin
      last_wr <= fn_wr;
      n_wr <= n_wr + 1;
    end
    if (software_commit_bit === 1'b1) n_commit <= n_commit + 1;
  end

  function automatic logic [7:0] exp_sel(input logic [7:0] d);
    return {2'b00, d[5:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [12:0] ad, input logic [7:0] d);
    logic [7:0] dummy;
    u_adcsc_host.frame(1'b0, 2'b00, ad, d, 24, dummy);
  endtask

  task automatic rd(input logic [12:0] ad, output logic [7:0] d);
    u_adcsc_host.frame(1'b1, 2'b00, ad, 8'h00, 24, d);
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang is cut short here and reported as a failure.
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    summarize();
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'ha3ea));
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (2) @(posedge mclk);
    chk({lsb_first, software_commit_bit, chan_sel}, 8'h0f);
    rd(13'h0000, rq);
    chk(rq, 8'h18);
    rd(13'h0002, rq);
    chk(rq, 8'h20);
    wr(13'h0001, 8'hff);
    rd(13'h0001, rq);
    chk(rq, 8'h5a);
    for (i = 0; i < 8; i++) begin
      v = i == 0 ? 8'hc0 : (i == 1 ? 8'h3f : 8'($urandom));
      wr(13'h0005, v);
      chk({2'b00, chan_sel}, exp_sel(v));
      rd(13'h0005, rq);
      chk(rq, exp_sel(v));
      a = 13'h0008 + 13'($urandom_range(26));
      wr(a, v ^ 8'h5a);
      chk(last_wr, {1'b1, a, v ^ 8'h5a, v[5:0]});
      chk(n_wr, i + 1);
    end
    // Streamed write of two bytes; MSB-first walks the address down.
    u_adcsc_host.frame(1'b0, 2'h3, 13'h0009, 8'ha5, 32, rq);
    chk(n_wr, 10);
    chk(last_wr, {1'b1, 13'h0008, 8'ha5, v[5:0]});
    wr(13'h00ff, 8'h01);
    chk(n_commit, 1);
    rd(13'h00ff, rq);
    chk(rq, 8'h00);
    u_adcsc_host.frame(1'b0, 2'b00, 13'h0005, 8'h33, 21, rq);
    chk({2'b00, chan_sel}, exp_sel(v));
    wr(13'h0005, 8'h06);
    chk(chan_sel, 6'h06);
    wr(13'h0000, 8'h42);
    chk(lsb_first, 1'b1);
    lsb_mode = 1'b1;
    wr(13'h0005, 8'h09);
    rd(13'h0005, rq);
    chk({rq, 2'b00, chan_sel}, 16'h0909);
    wr(13'h0000, 8'h24);
    lsb_mode = 1'b0;
    chk({lsb_first, 1'b0, chan_sel}, 8'h0f);
    wr(13'h0005, 8'h01);
    @(posedge mclk) #1 rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (2) @(posedge mclk);
    chk({lsb_first, software_commit_bit, chan_sel}, 8'h0f);
    summarize();
  end
endmodule
